// *** hw/mali_pkg.sv ***
// package: constants shared by the multi-axis linear interpolator
package mali_pkg;
  // --------------------------------------------------------------
  // register port
  // --------------------------------------------------------------
  localparam int         DW       = 16;
  localparam int         AW       = 4;
  localparam int         NAX      = 4;
  localparam logic [3:0] A_CMD    = 4'h0;  // write: command_reg
  localparam logic [3:0] A_CFG    = 4'h1;  // write: in-position enables, read select
  localparam logic [3:0] A_ASSIGN = 4'h5;  // write: axis_assign_reg
  localparam logic [3:0] A_DLO    = 4'h6;  // write: data_low_reg
  localparam logic [3:0] A_DHI    = 4'h7;  // write: data_high_reg
  localparam logic [3:0] A_STAT   = 4'h0;  // read: main_status_reg
  localparam logic [3:0] A_ERR    = 4'h2;  // read: axis_error_reg of selected axis
  localparam logic [3:0] A_POSL   = 4'h8;  // read: logical position low half
  localparam logic [3:0] A_POSH   = 4'h9;  // read: logical position high half
  // --------------------------------------------------------------
  // command codes, low byte of command_reg
  // --------------------------------------------------------------
  localparam logic [7:0] C_RANGE  = 8'h00;
  localparam logic [7:0] C_ACCEL  = 8'h02;
  localparam logic [7:0] C_INIT   = 8'h04;
  localparam logic [7:0] C_DRIVE  = 8'h05;
  localparam logic [7:0] C_FINISH = 8'h06;
  localparam logic [7:0] C_LIN2   = 8'h30;
  localparam logic [7:0] C_LIN3   = 8'h31;
  localparam logic [7:0] C_DECEL  = 8'h3B;
  // --------------------------------------------------------------
  // field positions and reset values
  // --------------------------------------------------------------
  localparam int         AS_PRI   = 0;
  localparam int         AS_SEC   = 2;
  localparam int         AS_TER   = 4;
  localparam int         CFG_SEL  = 4;     // cfg bits 5:4 pick the axis read back
  localparam int         ST_DRV   = 0;
  localparam int         ST_ERR   = 4;
  localparam int         ST_INTERP_DRIVING_FLAG  = 8;
  localparam int         E_SLP    = 0;
  localparam int         E_SLM    = 1;
  localparam int         E_HLP    = 2;
  localparam int         E_HLM    = 3;
  localparam logic [5:0] ASSIGN_RST = 6'h00;
  localparam logic [31:0] FIN_MAX = 32'h7FFF_FFFE;  // full span less two lsbs
  localparam logic [31:0] FIN_MIN = 32'h8000_0002;
  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int CLK_HZ    = 50_000_000;
  localparam int MAX_PPS   = 4_000_000;
  localparam int CONT_PPS  = 2_000_000;
  localparam int RANGE_REF = 8_000_000;   // range giving multiple 1
  localparam int ACC_UNIT  = 125;
  localparam int MIN_TICK  = (CLK_HZ + MAX_PPS - 1) / MAX_PPS;
  localparam int CONT_TICK = (CLK_HZ + CONT_PPS - 1) / CONT_PPS;
  localparam int RATE_NUM  = RANGE_REF / 1_000_000;
  localparam int RATE_DEN  = CLK_HZ / 1_000_000;
endpackage : mali_pkg

// *** hw/mali_rate_if.sv ***
// interface: pulse rate generator control between interpolator and generator
`timescale 1ns/1ps
interface mali_rate_if;
  logic        start;
  logic        halt;
  logic        ramp_en;
  logic [15:0] init_spd;
  logic [15:0] drv_spd;
  logic [15:0] accel;
  logic [31:0] range;
  logic [31:0] remain;
  logic        tick;
  modport ctrl (output start, halt, ramp_en, init_spd, drv_spd, accel, range, remain, input tick);
  modport gen  (input start, halt, ramp_en, init_spd, drv_spd, accel, range, remain, output tick);
endinterface : mali_rate_if

// *** hw/mali_rate_gen.sv ***
// module: long-axis pulse rate generator with symmetric ramp
`timescale 1ns/1ps
module mali_rate_gen (
  input wire logic sys_clk,
  input wire logic nrst,
  mali_rate_if.gen rif
);
  localparam logic [3:0]  GAP    = 4'(mali_pkg::MIN_TICK - 1);
  localparam logic [31:0] CLK32  = 32'(mali_pkg::CLK_HZ);

  logic [15:0] cv_r;
  logic [39:0] acc_r;
  logic [31:0] ramp_r;
  logic [31:0] up_r;
  logic [3:0]  gap_r;
  logic        run_r;
  logic        tick_r;

  // --------------------------------------------------------------
  // rate arithmetic
  // --------------------------------------------------------------
  // speed*8/(range*50) ticks per clock equals speed*8e6/range pps
  wire [15:0] spd_w      = rif.ramp_en ? cv_r : rif.drv_spd;
  wire [39:0] acc_sum_w  = acc_r + 40'(spd_w) * 40'(mali_pkg::RATE_NUM);
  wire [39:0] thr_w      = 40'(rif.range) * 40'(mali_pkg::RATE_DEN);
  wire        gap_ok_w   = (gap_r == 4'h0);
  wire        fire_w     = gap_ok_w && (acc_sum_w >= thr_w);
  wire [31:0] ramp_sum_w = ramp_r + 32'(rif.accel) * 32'(mali_pkg::ACC_UNIT);
  wire        ramp_w     = rif.ramp_en && (ramp_sum_w >= CLK32);
  // slow down once the pulses left fit in what the climb used
  wire        decel_w    = (rif.remain <= up_r);
  wire        climb_w    = !decel_w && (cv_r < rif.drv_spd);

  assign rif.tick = tick_r;

  // --------------------------------------------------------------
  // generator state
  // --------------------------------------------------------------
  // the gap counter caps the rate; excess phase is held, not lost
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      run_r  <= 1'b0;
      tick_r <= 1'b0;
      cv_r   <= 16'h0000;
      acc_r  <= 40'h00_0000_0000;
      ramp_r <= 32'h0000_0000;
      up_r   <= 32'h0000_0000;
      gap_r  <= 4'h0;
    end
    else if (rif.start)
    begin
      run_r  <= 1'b1;
      tick_r <= 1'b0;
      cv_r   <= rif.init_spd;
      acc_r  <= 40'h00_0000_0000;
      ramp_r <= 32'h0000_0000;
      up_r   <= 32'h0000_0000;
      gap_r  <= 4'h0;
    end
    else if (rif.halt || !run_r)
    begin
      run_r  <= 1'b0;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= fire_w;
      acc_r  <= !gap_ok_w ? acc_r : (fire_w ? acc_sum_w - thr_w : acc_sum_w);
      gap_r  <= fire_w ? GAP : (gap_ok_w ? 4'h0 : gap_r - 4'h1);
      ramp_r <= ramp_w ? ramp_sum_w - CLK32 : (rif.ramp_en ? ramp_sum_w : 32'h0000_0000);
      if (ramp_w && decel_w && (cv_r > rif.init_spd))
        cv_r <= cv_r - 16'h0001;
      else if (ramp_w && climb_w)
        cv_r <= cv_r + 16'h0001;
      if (fire_w && climb_w)
        up_r <= up_r + 32'h0000_0001;
    end
  end
endmodule : mali_rate_gen

// *** hw/mali_top.sv ***
// module: multi-axis linear interpolator, register port and axis pulse logic
// Functional notes
// - linear on two or three of four axes
// - assign fields: primary, secondary, tertiary, 2 bits
// - each field holds the physical axis number
// - speed comes from primary axis parameters
// - any selected axis may be the longest
// - code 30h starts two-axis linear drive
// - code 31h three-axis; 3Bh enables ramp
// - data halves, axis bitmap, 06h loads finish
// - 00h,02h,04h,05h load speed parameters per axis
// - status bit 8 high while interpolating
// - driving bit set for each participating axis
// - output rate capped at 4 MPPS
// - limits of participating axes stop the drive
// - error stop sets status and error register
// - either-direction limit stops the drive
// - busy ends after pulses and in-position
// - finish counts signed, relative to position
// - path within half an lsb
// - long axis even, short axes follow ratio
// - finish clamped to signed 32 less 2lsb
// - logical position tracks every output pulse
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module mali_top (
  input  wire logic                     sys_clk,
  input  wire logic                     nrst,
  input  wire logic [mali_pkg::AW-1:0]  reg_addr,
  input  wire logic [mali_pkg::DW-1:0]  reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [mali_pkg::DW-1:0]  reg_rdata,
  input  wire logic [mali_pkg::NAX-1:0] hw_limit_p_n,
  input  wire logic [mali_pkg::NAX-1:0] hw_limit_m_n,
  input  wire logic [mali_pkg::NAX-1:0] soft_limit_p,
  input  wire logic [mali_pkg::NAX-1:0] soft_limit_m,
  input  wire logic [mali_pkg::NAX-1:0] servo_inposition_in,
  output logic      [mali_pkg::NAX-1:0] pulse_p,
  output logic      [mali_pkg::NAX-1:0] pulse_m,
  output logic                          interp_driving_flag,
  output logic      [mali_pkg::NAX-1:0] axis_driving_flag
);
  localparam int N = mali_pkg::NAX;

  typedef enum logic [2:0] {
    MALI_IDLE  = 3'b001,
    MALI_RUN   = 3'b010,
    MALI_INPOS = 3'b100
  } mali_state_t;

  mali_state_t state_r;
  mali_state_t state_nxt;
  mali_rate_if rif ();

  // host-written registers
  logic [15:0] dlo_r;
  logic [15:0] dhi_r;
  logic [5:0]  assign_r;
  logic [5:0]  cfg_r;
  logic        ramp_en_r;

  // motion state
  logic [N-1:0] part_r;
  logic [31:0] long_r;
  logic [31:0] step_cnt_r;
  logic [31:0] long_w;

  // pin synchroniser and read data
  logic [3*N-1:0] sy1_r;
  logic [3*N-1:0] sy2_r;
  logic [15:0] rdata_r;

  // per-axis storage
  logic [31:0] range_r [N];
  logic [15:0] accel_r [N];
  logic [15:0] init_r  [N];
  logic [15:0] drive_r [N];
  logic [31:0] fin_r   [N];
  logic [31:0] abs_r   [N];
  logic [31:0] abs_w   [N];
  logic [31:0] err_r   [N];
  logic [31:0] pos_r   [N];
  logic [3:0]  aerr_r  [N];

  // per-axis decode
  logic [N-1:0] neg_r;
  logic [N-1:0] step_w;
  logic [N-1:0] lim_w;
  logic [N-1:0] pp_r;
  logic [N-1:0] pm_r;

  // --------------------------------------------------------------
  // command decode
  // --------------------------------------------------------------
  wire        wr_cmd_w  = reg_wr && (reg_addr == mali_pkg::A_CMD);
  wire [7:0]  code_w    = reg_wdata[7:0];
  wire [N-1:0] map_w    = reg_wdata[8 +: N];
  wire [31:0] data_w    = {dhi_r, dlo_r};
  wire        idle_w    = (state_r == MALI_IDLE);
  wire        run_w     = (state_r == MALI_RUN);
  // circular and bit-pattern codes are decoded as no-ops here
  wire        lin2_w    = wr_cmd_w && (code_w == mali_pkg::C_LIN2);
  wire        lin3_w    = wr_cmd_w && (code_w == mali_pkg::C_LIN3);
  wire        start_w   = idle_w && (lin2_w || lin3_w);

  // axis fields carry physical axis numbers
  wire [1:0]  pri_w     = assign_r[mali_pkg::AS_PRI +: 2];
  wire [1:0]  sec_w     = assign_r[mali_pkg::AS_SEC +: 2];
  wire [1:0]  ter_w     = assign_r[mali_pkg::AS_TER +: 2];
  wire [N-1:0] sel2_w   = (N'(1) << pri_w) | (N'(1) << sec_w);
  wire [N-1:0] sel_w    = lin3_w ? (sel2_w | (N'(1) << ter_w)) : sel2_w;

  // --------------------------------------------------------------
  // synchronised pins and stop conditions
  // --------------------------------------------------------------
  wire [N-1:0] hlp_w    = ~sy2_r[0 +: N];
  wire [N-1:0] hlm_w    = ~sy2_r[N +: N];
  wire [N-1:0] inp_w    = sy2_r[2*N +: N];
  wire        lim_hit_w = run_w && |(part_r & lim_w);
  wire [N-1:0] inpos_en_w = cfg_r[N-1:0];
  wire        inpos_ok_w = ((part_r & inpos_en_w & ~inp_w) == '0);
  wire        done_w    = (step_cnt_r == long_r);
  wire        tick_ok_w = run_w && rif.tick && !done_w && !lim_hit_w;

  // --------------------------------------------------------------
  // rate generator hookup, speed parameters from the primary axis, remain from the long-axis count
  // --------------------------------------------------------------
  assign rif.start    = start_w;
  assign rif.halt     = !run_w;
  assign rif.ramp_en  = ramp_en_r;
  assign rif.init_spd = init_r[pri_w];
  assign rif.drv_spd  = drive_r[pri_w];
  assign rif.accel    = accel_r[pri_w];
  assign rif.range    = range_r[pri_w];
  assign rif.remain   = long_r - step_cnt_r;

  // pulse spacing never drops below the 4 MPPS period
  mali_rate_gen u_rate (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .rif     (rif.gen)
  );

  // longest selected distance drives the step count
  always_comb
  begin
    long_w = 32'h0000_0000;
    for (int k = 0; k < N; k++)
      if (sel_w[k] && (abs_w[k] > long_w))
        long_w = abs_w[k];
  end

  // --------------------------------------------------------------
  // status and read back
  // --------------------------------------------------------------
  logic [N-1:0] err_any_w;
  wire  [1:0]   rsel_w = cfg_r[mali_pkg::CFG_SEL +: 2];
  wire  [15:0]  stat_w = {7'h00, !idle_w, err_any_w, axis_driving_flag};
  wire  [15:0]  rmux_w = (reg_addr == mali_pkg::A_STAT) ? stat_w :
                         (reg_addr == mali_pkg::A_ERR)  ? {12'h000, aerr_r[rsel_w]} :
                         (reg_addr == mali_pkg::A_POSL) ? pos_r[rsel_w][15:0] :
                         (reg_addr == mali_pkg::A_POSH) ? pos_r[rsel_w][31:16] : 16'h0000;

  assign interp_driving_flag = !idle_w;
  assign axis_driving_flag   = idle_w ? '0 : part_r;
  assign reg_rdata           = rdata_r;
  assign pulse_p             = pp_r;
  assign pulse_m             = pm_r;

  // read data only in the cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      rdata_r <= 16'h0000;
    else
      rdata_r <= reg_rd ? rmux_w : 16'h0000;
  end

  // --------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------
  // the ramp flag persists until reset; linear starts honour it
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      dlo_r     <= 16'h0000;
      dhi_r     <= 16'h0000;
      assign_r  <= mali_pkg::ASSIGN_RST;
      cfg_r     <= 6'h00;
      ramp_en_r <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == mali_pkg::A_DLO)
        dlo_r <= reg_wdata;
      if (reg_addr == mali_pkg::A_DHI)
        dhi_r <= reg_wdata;
      if (reg_addr == mali_pkg::A_ASSIGN)
        assign_r <= reg_wdata[5:0];
      if (reg_addr == mali_pkg::A_CFG)
        cfg_r <= reg_wdata[5:0];
      if (wr_cmd_w && (code_w == mali_pkg::C_DECEL))
        ramp_en_r <= 1'b1;
    end
  end

  // two-flop synchroniser for limit and in-position pins
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      sy1_r <= '0;
      sy2_r <= '0;
    end
    else
    begin
      sy1_r <= {servo_inposition_in, hw_limit_m_n, hw_limit_p_n};
      sy2_r <= sy1_r;
    end
  end

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  always_comb
  begin
    case (state_r)
      MALI_IDLE:  state_nxt = start_w ? MALI_RUN : MALI_IDLE;
      MALI_RUN:   state_nxt = lim_hit_w ? MALI_IDLE : (done_w ? MALI_INPOS : MALI_RUN);
      MALI_INPOS: state_nxt = inpos_ok_w ? MALI_IDLE : MALI_INPOS;
      default:    state_nxt = MALI_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      state_r    <= MALI_IDLE;
      part_r     <= '0;
      long_r     <= 32'h0000_0000;
      step_cnt_r <= 32'h0000_0000;
    end
    else
    begin
      state_r <= state_nxt;
      if (start_w)
      begin
        part_r     <= sel_w;
        long_r     <= long_w;
        step_cnt_r <= 32'h0000_0000;
      end
      else if (tick_ok_w)
        step_cnt_r <= step_cnt_r + 32'h0000_0001;
    end
  end

  // --------------------------------------------------------------
  // per-axis parameters, interpolation and position
  // --------------------------------------------------------------
  for (genvar i = 0; i < N; i++)
  begin : g_ax
    wire        load_w = wr_cmd_w && map_w[i];
    wire [31:0] sum_w  = err_r[i] + abs_r[i];
    wire        pneg_w = fin_r[i][31];
    // clamp keeps the magnitude within 31 bits
    wire [31:0] clip_w = ($signed(data_w) > $signed(mali_pkg::FIN_MAX)) ? mali_pkg::FIN_MAX :
                         ($signed(data_w) < $signed(mali_pkg::FIN_MIN)) ? mali_pkg::FIN_MIN : data_w;

    assign abs_w[i]  = pneg_w ? (32'h0000_0000 - fin_r[i]) : fin_r[i];
    // short axes step when the accumulated ratio crosses long
    assign step_w[i] = part_r[i] && tick_ok_w && (sum_w >= long_r);
    assign lim_w[i]  = hlp_w[i] | hlm_w[i] | soft_limit_p[i] | soft_limit_m[i];
    assign err_any_w[i] = |aerr_r[i];

    // parameter loads by command and axis bitmap
    always_ff @(posedge sys_clk)
    begin
      if (!nrst)
      begin
        range_r[i] <= 32'h0000_0000;
        accel_r[i] <= 16'h0000;
        init_r[i]  <= 16'h0000;
        drive_r[i] <= 16'h0000;
        fin_r[i]   <= 32'h0000_0000;
      end
      else if (load_w)
      begin
        case (code_w)
          mali_pkg::C_RANGE:  range_r[i] <= data_w;
          mali_pkg::C_ACCEL:  accel_r[i] <= dlo_r;
          mali_pkg::C_INIT:   init_r[i]  <= dlo_r;
          mali_pkg::C_DRIVE:  drive_r[i] <= dlo_r;
          mali_pkg::C_FINISH: fin_r[i]   <= clip_w;
          default:            fin_r[i]   <= fin_r[i];
        endcase
      end
    end

    // error seeded at half of long bounds deviation to half an lsb
    always_ff @(posedge sys_clk)
    begin
      if (!nrst)
      begin
        err_r[i] <= 32'h0000_0000;
        abs_r[i] <= 32'h0000_0000;
        neg_r[i] <= 1'b0;
      end
      else if (start_w)
      begin
        err_r[i] <= long_w >> 1;
        abs_r[i] <= abs_w[i];
        neg_r[i] <= pneg_w;
      end
      else if (tick_ok_w)
        err_r[i] <= step_w[i] ? sum_w - long_r : sum_w;
    end

    // pulses and logical position; set beats the start clear
    always_ff @(posedge sys_clk)
    begin
      if (!nrst)
      begin
        pp_r[i]   <= 1'b0;
        pm_r[i]   <= 1'b0;
        pos_r[i]  <= 32'h0000_0000;
        aerr_r[i] <= 4'h0;
      end
      else
      begin
        pp_r[i] <= step_w[i] && !neg_r[i];
        pm_r[i] <= step_w[i] && neg_r[i];
        if (step_w[i])
          pos_r[i] <= neg_r[i] ? pos_r[i] - 32'h0000_0001 : pos_r[i] + 32'h0000_0001;
        aerr_r[i] <= (start_w ? 4'h0 : aerr_r[i]) |
                     ({hlm_w[i], hlp_w[i], soft_limit_m[i], soft_limit_p[i]} & {4{run_w && part_r[i]}});
      end
    end
  end
endmodule : mali_top

// *** testbench/mali_monitor.sv ***
// checker: port-level properties of the interpolator
`timescale 1ns/1ps
module mali_monitor (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [3:0]  soft_limit_p,
  input wire logic [3:0]  soft_limit_m,
  input wire logic [3:0]  pulse_p,
  input wire logic [3:0]  pulse_m,
  input wire logic        interp_driving_flag,
  input wire logic [3:0]  axis_driving_flag
);
  // --------------------
  // helpers
  // --------------------
  // decoded start writes and watched limits
  wire logic [3:0] pm     = pulse_p | pulse_m;
  wire logic       cmd_wr = reg_wr && reg_addr == mali_pkg::A_CMD;
  wire logic       st2    = cmd_wr && reg_wdata[7:0] == mali_pkg::C_LIN2;
  wire logic       st3    = cmd_wr && reg_wdata[7:0] == mali_pkg::C_LIN3;
  wire logic       lim    = |((soft_limit_p | soft_limit_m) & axis_driving_flag);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // --------------------
  // properties
  // --------------------
  AST_PULSE_DIR:
    assert property ((pulse_p & pulse_m) == 4'h0) else $error("both directions at once");
  AST_PULSE_BUSY:
    assert property (|pm |-> $past(interp_driving_flag)) else $error("pulse while idle");
  AST_PULSE_PART:
    assert property (|pm |-> (pm & ~$past(axis_driving_flag)) == 4'h0) else $error("pulse on idle axis");
  AST_DRV_BUSY:
    assert property (|axis_driving_flag |-> interp_driving_flag) else $error("axis flag without busy");
  AST_START2:
    assert property (st2 && !interp_driving_flag |=> interp_driving_flag && axis_driving_flag != 4'h0)
      else $error("two-axis start missed");
  AST_START3:
    assert property (st3 && !interp_driving_flag |=> interp_driving_flag) else $error("three-axis start missed");
  AST_SPACING:
    assert property (|pm |=> (pm == 4'h0)[*8]) else $error("pulses too close");
  AST_LIMIT:
    assert property (interp_driving_flag && lim |-> ##[1:3] !interp_driving_flag) else $error("limit ignored");
  AST_RDATA_IDLE:
    assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data outside slot");
endmodule : mali_monitor

bind mali_top mali_monitor mali_monitor_i (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .soft_limit_p(soft_limit_p), .soft_limit_m(soft_limit_m), .pulse_p(pulse_p), .pulse_m(pulse_m),
  .interp_driving_flag(interp_driving_flag), .axis_driving_flag(axis_driving_flag));

// *** testbench/mali_host_model.sv ***
// model: host cpu on the register port
`timescale 1ns/1ps
module mali_host_model (
  input  wire logic        sys_clk,
  input  wire logic [15:0] reg_rdata,
  output logic      [3:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd
);
  // --------------------
  // bus cycles
  // --------------------
  // idle bus from time zero
  initial
  begin
    reg_addr  = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // strobe held up to its sampling edge, dropped right after
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr
  // data sits in the cycle after the strobe edge only
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  // low half, high half, then axis bitmap and code
  task automatic ld(input logic [3:0] ax, input logic [7:0] code, input logic [31:0] v);
    wr(mali_pkg::A_DLO, v[15:0]);
    wr(mali_pkg::A_DHI, v[31:16]);
    wr(mali_pkg::A_CMD, {4'h0, ax, code});
  endtask : ld
endmodule : mali_host_model

// *** testbench/test_multi_axis_linear_interpolator.sv ***
// testbench: linear interpolation through the register port
`timescale 1ns/1ps
module test_multi_axis_linear_interpolator;
  logic        sys_clk, nrst, reg_wr, reg_rd, busy;
  logic [3:0]  reg_addr, hw_p_n, hw_m_n, sl_p, sl_m, inpos, pulse_p, pulse_m, adrv;
  logic [15:0] reg_wdata, reg_rdata, d, e;
  int          np[4], nm[4];
  int          failures;
  int          n_compared;
  // --------------------
  // clock, reset, instances
  // --------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  mali_host_model mali_host_model_i (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  mali_top mali_top_i (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_limit_p_n(hw_p_n), .hw_limit_m_n(hw_m_n),
    .soft_limit_p(sl_p), .soft_limit_m(sl_m), .servo_inposition_in(inpos), .pulse_p(pulse_p),
    .pulse_m(pulse_m), .interp_driving_flag(busy), .axis_driving_flag(adrv));
  // pulse tally per axis, cleared by go at each drive start
  always @(posedge sys_clk)
    for (int i = 0; i < 4; i++)
    begin
      if (pulse_p[i] === 1'b1) np[i]++;
      if (pulse_m[i] === 1'b1) nm[i]++;
    end
  // --------------------
  // shared tasks
  // --------------------
  task automatic chk(input bit ok, input string s);
    n_compared++;
    if (!ok)
    begin
      failures++;
      $display("mismatch t=%0t %s", $time, s);
    end
  endtask : chk
  // start a drive; flags rise the cycle after the write
  task automatic go(input logic [7:0] c, input logic [3:0] part);
    np = '{0, 0, 0, 0};
    nm = '{0, 0, 0, 0};
    mali_host_model_i.wr(mali_pkg::A_CMD, {8'h00, c});
    #1;
    chk(busy === 1'b1 && adrv === part, "flags at start");
  endtask : go
  task automatic idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 3000)
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk(k < 3000, "drive never ended");
  endtask : idle
  // read back one axis; in-position enables off
  task automatic pos(input logic [1:0] ax, input logic [31:0] x);
    mali_host_model_i.wr(mali_pkg::A_CFG, {10'h000, ax, 4'h0});
    mali_host_model_i.rd(mali_pkg::A_POSL, d);
    mali_host_model_i.rd(mali_pkg::A_POSH, e);
    chk({e, d} === x, "logical position");
  endtask : pos
  // --------------------
  // scenarios
  // --------------------
  task automatic t_reset();
    mali_host_model_i.rd(mali_pkg::A_STAT, d);
    chk(d === 16'h0000, "status after reset");
    mali_host_model_i.rd(4'h3, d);
    chk(d === 16'h0000, "unmapped read");
  endtask : t_reset
  // X +5, Y -3; range 1 with speed 7 gives the 13-cycle floor
  task automatic t_lin2();
    mali_host_model_i.wr(mali_pkg::A_ASSIGN, 16'h0004);
    mali_host_model_i.ld(4'h1, mali_pkg::C_RANGE, 32'h0000_0001);
    mali_host_model_i.ld(4'h1, mali_pkg::C_ACCEL, 32'h0000_0000);
    mali_host_model_i.ld(4'h1, mali_pkg::C_INIT, 32'h0000_0007);
    mali_host_model_i.ld(4'h1, mali_pkg::C_DRIVE, 32'h0000_0007);
    mali_host_model_i.ld(4'h1, mali_pkg::C_FINISH, 32'h0000_0005);
    mali_host_model_i.ld(4'h2, mali_pkg::C_FINISH, 32'hFFFF_FFFD);
    go(mali_pkg::C_LIN2, 4'h3);
    mali_host_model_i.rd(mali_pkg::A_STAT, d);
    chk(d === 16'h0103, "status while driving");
    idle();
    chk(np[0] == 5 && nm[1] == 3 && nm[0] + np[1] + np[2] + nm[2] == 0, "two-axis counts");
    pos(2'h0, 32'h0000_0005);
    pos(2'h1, 32'hFFFF_FFFD);
  endtask : t_lin2
  // Z travels farthest though X is primary; ramp enabled first
  task automatic t_lin3();
    mali_host_model_i.wr(mali_pkg::A_ASSIGN, 16'h0024);
    mali_host_model_i.ld(4'h1, mali_pkg::C_FINISH, 32'h0000_0002);
    mali_host_model_i.ld(4'h2, mali_pkg::C_FINISH, 32'hFFFF_FFFC);
    mali_host_model_i.ld(4'h4, mali_pkg::C_FINISH, 32'h0000_0007);
    mali_host_model_i.wr(mali_pkg::A_CMD, {8'h00, mali_pkg::C_DECEL});
    go(mali_pkg::C_LIN3, 4'h7);
    idle();
    chk(np[0] == 2 && nm[1] == 4 && np[2] == 7 && nm[0] + np[1] + nm[2] == 0, "three-axis counts");
  endtask : t_lin3
  // a secondary-axis limit stops a long move; errors stay latched
  task automatic t_limit(input bit hw);
    int a;
    int k;
    mali_host_model_i.wr(mali_pkg::A_ASSIGN, 16'h0004);
    mali_host_model_i.ld(4'h1, mali_pkg::C_FINISH, 32'h0000_0028);
    mali_host_model_i.ld(4'h2, mali_pkg::C_FINISH, 32'hFFFF_FFF6);
    go(mali_pkg::C_LIN2, 4'h3);
    k = 0;
    while (np[0] < 3 && k < 500)
    begin
      @(posedge sys_clk);
      k++;
    end
    if (hw) hw_m_n[1] <= 1'b0;
    else sl_p[1] <= 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    chk(busy === 1'b0, "limit did not stop");
    a = np[0] + nm[1];
    repeat (30) @(posedge sys_clk);
    hw_m_n <= 4'hF;
    sl_p   <= 4'h0;
    chk(np[0] + nm[1] == a, "pulses after stop");
    mali_host_model_i.rd(mali_pkg::A_STAT, d);
    chk(d[mali_pkg::ST_ERR+1] === 1'b1, "error bit");
    mali_host_model_i.wr(mali_pkg::A_CFG, 16'h0010);
    mali_host_model_i.rd(mali_pkg::A_ERR, d);
    chk(d[3:0] === (hw ? 4'h8 : 4'h1), "error cause");
  endtask : t_limit
  // busy outlasts the pulses until the enabled axis reports in position
  task automatic t_inpos();
    int k;
    mali_host_model_i.wr(mali_pkg::A_CFG, 16'h0001);
    mali_host_model_i.ld(4'h1, mali_pkg::C_FINISH, 32'h0000_0002);
    mali_host_model_i.ld(4'h2, mali_pkg::C_FINISH, 32'h0000_0001);
    inpos <= 4'hE;
    go(mali_pkg::C_LIN2, 4'h3);
    k = 0;
    while (np[0] < 2 && k < 500)
    begin
      @(posedge sys_clk);
      k++;
    end
    repeat (20) @(posedge sys_clk);
    inpos <= 4'hF;
    #1;
    chk(busy === 1'b1, "busy dropped early");
    repeat (6) @(posedge sys_clk);
    #1;
    chk(busy === 1'b0, "busy held after in-position");
  endtask : t_inpos
  // --------------------
  // sequence and verdict
  // --------------------
  task automatic conclude();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  initial
  begin
    nrst   = 1'b0;
    hw_p_n = 4'hF;
    hw_m_n = 4'hF;
    sl_p   = 4'h0;
    sl_m   = 4'h0;
    inpos  = 4'hF;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_lin2();
    t_lin3();
    t_limit(1'b0);
    t_limit(1'b1);
    t_inpos();
    conclude();
  end
  // watchdog well beyond the several hundred cycles the scenarios need
  initial
  begin
    #1_000_000;
    failures++;
    conclude();
  end
endmodule : test_multi_axis_linear_interpolator
